// >>> design/pcg_clock_gen.sv
// Peripheral clock gates, source selectors and dividers behind APB
`timescale 1ns/100ps
`default_nettype none
module pcg_clock_gen
   import pcg_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire pcg_srcs_t         src_i,
   output pcg_gates_t             gates_o,
   output pcg_clks_t              clks_o,
   output pcg_osc_t               osc_o
);

   localparam pcg_state_t ST_RST = '{reg_xtal: RST_XTAL, default: '0};

   logic [1:0]                   rst_pipe_q;
   logic                         rst_sync_n;
   pcg_state_t                   q;
   pcg_state_t                   d;
   logic [7:0]                   src_lvl;
   logic [7:0]                   src_tick;
   logic [NUM_CH-1:0][2:0]       req_sel;
   logic [NUM_CH-1:0][CNT_W-1:0] req_div;
   logic [NUM_CH-1:0]            req_en;
   logic                         setup;
   logic                         wr_go;
   logic                         hit;
   logic [31:0]                  rd;
   logic [CNT_W-1:0]             sd_base;
   logic [8:0]                   pwm_code;
   logic [3:0]                   spi_code;

   // Reset is released through two stages so every flop of the state q leaves it together
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe_q <= 2'b00;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe_q[1];

   // Source levels come from the second sync stage, bit 1 gated by the crystal enable; bit 6 is the divided PLL level pll10_lvl, bit 7 is 0
   always_comb begin
      src_lvl = {1'b0, q.pll10_lvl, q.sync2};
      src_lvl[SRC_XTAL] = q.sync2[SRC_XTAL] & q.reg_xtal[XTAL_EN_BIT];
      src_tick = src_lvl & ~{1'b0, q.prev};
   end

   // Requested selection, divisor and gate per output channel
   always_comb begin
      sd_base  = {9'h000, q.reg_sd[SD_DIV_LSB +: 3]} + 12'h001;
      pwm_code = q.reg_pwm[8:0];
      spi_code = q.reg_spi[3:0];
      req_sel[CH_SD] = q.reg_sd[SD_SRC_BIT] ? SRC_PLL : SRC_XTAL;
      req_div[CH_SD] = q.reg_sd[SD_PRE_BIT] ? (sd_base << SD_PRE_SHIFT)
                                            : sd_base;
      unique case (q.reg_tun[1:0])
         2'b00: req_sel[CH_TUN] = SRC_F32K;
         2'b01: req_sel[CH_TUN] = SRC_XTAL;
         2'b10: req_sel[CH_TUN] = SRC_PLL10;
         2'b11: req_sel[CH_TUN] = SRC_F24;
      endcase
      req_div[CH_TUN] = 12'h001;
      req_sel[CH_PWM] = q.reg_pwm[PWM_SRC_BIT] ? SRC_XTAL : SRC_F32K;
      // Reserved codes above 256 fall back to the slowest ratio
      if (!pwm_code[8]) begin
         req_div[CH_PWM] = {3'h0, pwm_code} + 12'h001;
      end else if (pwm_code == 9'h100) begin
         req_div[CH_PWM] = PWM_DIV_512;
      end else begin
         req_div[CH_PWM] = PWM_DIV_1024;
      end
      unique case (q.reg_spi[SPI_SRC_LSB +: 2])
         2'b00: req_sel[CH_SPI] = SRC_CPU;
         2'b01: req_sel[CH_SPI] = SRC_XTAL;
         2'b10: req_sel[CH_SPI] = SRC_PLL;
         2'b11: req_sel[CH_SPI] = SRC_F48;
      endcase
      req_div[CH_SPI] = (spi_code == 4'h0) ? 12'h001
                                           : {7'h00, spi_code, 1'b0};
      req_sel[CH_UART] = q.reg_uart[0] ? SRC_F24 : SRC_XTAL;
      req_div[CH_UART] = 12'h001;
      req_en[CH_SD]   = q.reg_gate[GATE_SD_BIT];
      req_en[CH_TUN]  = q.reg_gate[GATE_TUN_BIT];
      req_en[CH_PWM]  = q.reg_gate[GATE_PWM_BIT];
      req_en[CH_SPI]  = q.reg_gate[GATE_SPI_BIT];
      req_en[CH_UART] = q.reg_gate[GATE_UART_BIT];
   end

   // APB decode; the answer is registered at the end of setup, so no access has a wait
   assign setup = psel & ~penable;
   assign wr_go = psel & penable & q.pready & pwrite & ~q.pslverr;

   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         OFS_XTAL: rd = q.reg_xtal;
         OFS_GATE: rd = q.reg_gate;
         OFS_SD:   rd = q.reg_sd;
         OFS_TUN:  rd = q.reg_tun;
         OFS_PWM:  rd = q.reg_pwm;
         OFS_SPI:  rd = q.reg_spi;
         OFS_UART: rd = q.reg_uart;
         default: begin
            rd  = 32'h0000_0000;
            hit = 1'b0;
         end
      endcase
   end

   always_comb begin
      logic             lvl;
      logic             tk;
      logic             commit;
      logic             from_lvl;
      logic [CNT_W-1:0] nxt;
      lvl      = 1'b0;
      tk       = 1'b0;
      commit   = 1'b0;
      from_lvl = 1'b0;
      nxt      = '0;
      d = q;
      d.sync1 = src_i;
      d.sync2 = q.sync1;
      d.prev  = src_lvl[6:0];
      if (src_tick[SRC_PLL]) begin
         d.pll10_cnt = (q.pll10_cnt == PLL10_LAST) ? 4'h0
                                                   : q.pll10_cnt + 4'h1;
         d.pll10_lvl = (d.pll10_cnt < PLL10_HIGH);
      end
      // APB answer and writes; stored bits are masked so reserved read 0
      d.pready  = setup & ~q.pready;
      d.pslverr = setup & ~hit;
      d.prdata  = (setup & ~pwrite) ? rd : 32'h0000_0000;
      if (wr_go) begin
         unique case (paddr)
            OFS_XTAL: d.reg_xtal = pwdata & MASK_XTAL;
            OFS_GATE: d.reg_gate = pwdata & MASK_GATE;
            OFS_SD:   d.reg_sd   = pwdata & MASK_SD;
            OFS_TUN:  d.reg_tun  = pwdata & MASK_TUN;
            OFS_PWM:  d.reg_pwm  = pwdata & MASK_PWM;
            OFS_SPI:  d.reg_spi  = pwdata & MASK_SPI;
            OFS_UART: d.reg_uart = pwdata & MASK_UART;
            default: ;
         endcase
      end
      // Dividers: new settings load at a period boundary, or in level mode while the source is low
      for (int c = 0; c < NUM_CH; c++) begin
         lvl      = src_lvl[q.sel_act[c]];
         tk       = src_tick[q.sel_act[c]];
         commit   = 1'b0;
         from_lvl = 1'b0;
         if (q.div_act[c] <= 12'h001) begin
            d.clk[c] = lvl;
            commit   = ~lvl;
            from_lvl = 1'b1;
         end else if (tk) begin
            if (q.cnt[c] == q.div_act[c] - 12'h001) begin
               d.cnt[c] = '0;
               d.clk[c] = 1'b1;
               commit   = 1'b1;
            end else begin
               nxt      = q.cnt[c] + 12'h001;
               d.cnt[c] = nxt;
               d.clk[c] = (nxt < (q.div_act[c] >> 1));
            end
         end
         if (commit) begin
            d.sel_act[c] = req_sel[c];
            d.div_act[c] = req_div[c];
            // Leaving level mode, the next edge starts a whole period
            d.cnt[c] = from_lvl ? req_div[c] - 12'h001 : '0;
         end
         // A gate flips only while the clock is low
         if (!q.clk[c]) begin
            d.en_act[c] = req_en[c];
         end
         d.clk_out[c] = d.clk[c] & d.en_act[c];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign clks_o  = pcg_clks_t'(q.clk_out);
   assign gates_o = pcg_gates_t'({q.reg_gate[GATE_HI_LSB +: 4],
                                  q.reg_gate[GATE_MID_LSB +: 7],
                                  q.reg_gate[2:0]});
   assign osc_o   = pcg_osc_t'({q.reg_xtal[XTAL_EN_BIT],
                                q.reg_xtal[IN_BASE_LSB +: 2],
                                q.reg_xtal[IN_TRIM_LSB +: 5],
                                q.reg_xtal[OUT_BASE_LSB +: 2],
                                q.reg_xtal[OUT_TRIM_LSB +: 5]});

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_sync_n);

   a_apb_ready_pulse: assert property (
      setup |=> pready ##1 !pready)
      else $error("ready did not pulse once after setup");
   a_unmapped_error: assert property (
      setup && !hit |=> pready && pslverr)
      else $error("unmapped access not flagged");
   a_rsvd_read_zero: assert property (
      setup && !pwrite && paddr == OFS_GATE
      |=> (prdata & ~MASK_GATE) == 32'h0000_0000)
      else $error("reserved gate bits read nonzero");
   a_gate_write_out: assert property (
      wr_go && paddr == OFS_GATE
      |=> gates_o == pcg_gates_t'({$past(pwdata[19:16]),
                                   $past(pwdata[10:4]),
                                   $past(pwdata[2:0])}))
      else $error("gate outputs do not follow write");
   a_osc_write_out: assert property (
      wr_go && paddr == OFS_XTAL
      |=> osc_o.crystal_oscillator_enable == $past(pwdata[0])
          && osc_o.input_pad_base_load == $past(pwdata[18:17])
          && osc_o.output_pad_load_trim == $past(pwdata[8:4]))
      else $error("oscillator fields do not follow write");
   a_xtal_stopped: assert property (
      !osc_o.crystal_oscillator_enable |-> !src_lvl[SRC_XTAL])
      else $error("crystal source active while disabled");
   a_sd_source_legal: assert property (
      q.div_act[CH_SD] != '0 |-> (q.sel_act[CH_SD] == SRC_XTAL
         || q.sel_act[CH_SD] == SRC_PLL) && q.div_act[CH_SD] <= SD_DIV_MAX)
      else $error("sd source or ratio out of range");
   a_pwm_source_legal: assert property (
      q.div_act[CH_PWM] != '0 |-> (q.sel_act[CH_PWM] == SRC_F32K
         || q.sel_act[CH_PWM] == SRC_XTAL)
         && q.div_act[CH_PWM] <= PWM_DIV_1024)
      else $error("pwm source or ratio out of range");
   a_spi_ratio_legal: assert property (
      q.div_act[CH_SPI] != '0 |-> q.div_act[CH_SPI] <= SPI_DIV_MAX
         && (q.div_act[CH_SPI] == 12'h001 || !q.div_act[CH_SPI][0])
         && q.sel_act[CH_SPI] != SRC_F24 && q.sel_act[CH_SPI] != SRC_F32K)
      else $error("spi source or ratio illegal");
   a_undivided_chans: assert property (
      q.div_act[CH_TUN] <= 12'h001 && q.div_act[CH_UART] <= 12'h001
      && q.sel_act[CH_UART] != SRC_PLL && q.sel_act[CH_TUN] != SRC_PLL)
      else $error("tuner or uart clock divided or bad source");

   for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
      a_gate_when_low: assert property (
         $changed(q.en_act[g]) |-> !$past(q.clk[g]))
         else $error("gate changed while clock high");
      a_count_bound: assert property (
         q.div_act[g] > 12'h001 |-> q.cnt[g] < q.div_act[g])
         else $error("divider count beyond ratio");
   end

   c_sd_clock_runs:  cover property ($rose(clks_o.sd_card_clk));
   c_pwm_slowest:    cover property (q.div_act[CH_PWM] == PWM_DIV_1024);
   c_apb_error:      cover property (pready && pslverr);
   c_spi_clock_runs: cover property ($rose(clks_o.spi_clk));

endmodule
`default_nettype wire

// >>> design/pcg_pkg.sv
// Package: register map, field layout and carrier types of the clock gen
package pcg_pkg;

   localparam int unsigned ADDR_W       = 12;
   localparam int unsigned CNT_W        = 12;
   localparam int unsigned CLK_SYS_HZ   = 20_000_000;
   localparam int unsigned XTAL_FREQ_HZ = 26_000_000;

   localparam logic [ADDR_W-1:0] OFS_XTAL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_GATE = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_SD   = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_TUN  = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_PWM  = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_SPI  = 12'h01C;
   localparam logic [ADDR_W-1:0] OFS_UART = 12'h020;

   localparam logic [31:0] MASK_XTAL = 32'h0007_F7F1;
   localparam logic [31:0] MASK_GATE = 32'h000F_07F7;
   localparam logic [31:0] MASK_SD   = 32'h0000_0117;
   localparam logic [31:0] MASK_TUN  = 32'h0000_0003;
   localparam logic [31:0] MASK_PWM  = 32'h0000_11FF;
   localparam logic [31:0] MASK_SPI  = 32'h0000_003F;
   localparam logic [31:0] MASK_UART = 32'h0000_0001;

   localparam logic [31:0] RST_XTAL  = 32'h0004_0401;

   localparam int unsigned XTAL_EN_BIT   = 0;
   localparam int unsigned IN_BASE_LSB   = 17;
   localparam int unsigned IN_TRIM_LSB   = 12;
   localparam int unsigned OUT_BASE_LSB  = 9;
   localparam int unsigned OUT_TRIM_LSB  = 4;
   localparam int unsigned GATE_HI_LSB   = 16;
   localparam int unsigned GATE_MID_LSB  = 4;
   localparam int unsigned GATE_SD_BIT   = 1;
   localparam int unsigned GATE_UART_BIT = 4;
   localparam int unsigned GATE_SPI_BIT  = 6;
   localparam int unsigned GATE_PWM_BIT  = 9;
   localparam int unsigned GATE_TUN_BIT  = 10;
   localparam int unsigned SD_PRE_BIT    = 8;
   localparam int unsigned SD_SRC_BIT    = 4;
   localparam int unsigned SD_DIV_LSB    = 0;
   localparam int unsigned PWM_SRC_BIT   = 12;
   localparam int unsigned SPI_SRC_LSB   = 4;

   localparam int unsigned SD_PRE_SHIFT = 8;
   localparam logic [3:0]  PLL10_LAST   = 4'h9;
   localparam logic [3:0]  PLL10_HIGH   = 4'h5;
   localparam logic [CNT_W-1:0] PWM_DIV_512  = 12'h200;
   localparam logic [CNT_W-1:0] PWM_DIV_1024 = 12'h400;
   localparam logic [CNT_W-1:0] SD_DIV_MAX   = 12'h800;
   localparam logic [CNT_W-1:0] SPI_DIV_MAX  = 12'h01E;

   // Source indices into the selector vector
   localparam logic [2:0] SRC_CPU   = 3'h0;
   localparam logic [2:0] SRC_XTAL  = 3'h1;
   localparam logic [2:0] SRC_PLL   = 3'h2;
   localparam logic [2:0] SRC_F24   = 3'h3;
   localparam logic [2:0] SRC_F32K  = 3'h4;
   localparam logic [2:0] SRC_F48   = 3'h5;
   localparam logic [2:0] SRC_PLL10 = 3'h6;

   localparam int unsigned NUM_CH  = 5;
   localparam int unsigned CH_SD   = 0;
   localparam int unsigned CH_TUN  = 1;
   localparam int unsigned CH_PWM  = 2;
   localparam int unsigned CH_SPI  = 3;
   localparam int unsigned CH_UART = 4;

   typedef struct packed {
      logic fixed_48mhz_clock;
      logic low_speed_32khz_clock;
      logic fixed_24mhz_clock;
      logic core_pll;
      logic crystal_oscillator;
      logic cpu_clk;
   } pcg_srcs_t;

   typedef struct packed {
      logic radio_frontend_clock_gate;
      logic modem_clock_gate;
      logic baseband_clock_gate;
      logic baseband_slow_clock_gate;
      logic tuner_clock_gate;
      logic pwm_clock_gate;
      logic dac_clock_gate;
      logic adc_clock_gate;
      logic spi_clock_gate;
      logic twi_clock_gate;
      logic uart_clock_gate;
      logic usb_clock_gate;
      logic sd_card_clock_gate;
      logic dma_clock_gate;
   } pcg_gates_t;

   typedef struct packed {
      logic uart_clk;
      logic spi_clk;
      logic pwm_clk;
      logic tuner_clk;
      logic sd_card_clk;
   } pcg_clks_t;

   typedef struct packed {
      logic       crystal_oscillator_enable;
      logic [1:0] input_pad_base_load;
      logic [4:0] input_pad_load_trim;
      logic [1:0] output_pad_base_load;
      logic [4:0] output_pad_load_trim;
   } pcg_osc_t;

   typedef struct packed {
      logic [5:0]                        sync1;
      logic [5:0]                        sync2;
      logic [6:0]                        prev;
      logic [3:0]                        pll10_cnt;
      logic                              pll10_lvl;
      logic [31:0]                       reg_xtal;
      logic [31:0]                       reg_gate;
      logic [31:0]                       reg_sd;
      logic [31:0]                       reg_tun;
      logic [31:0]                       reg_pwm;
      logic [31:0]                       reg_spi;
      logic [31:0]                       reg_uart;
      logic [NUM_CH-1:0][2:0]            sel_act;
      logic [NUM_CH-1:0][CNT_W-1:0]      div_act;
      logic [NUM_CH-1:0][CNT_W-1:0]      cnt;
      logic [NUM_CH-1:0]                 clk;
      logic [NUM_CH-1:0]                 en_act;
      logic [NUM_CH-1:0]                 clk_out;
      logic                              pready;
      logic                              pslverr;
      logic [31:0]                       prdata;
   } pcg_state_t;

endpackage

// >>> test/testbench.sv
// Self-checking testbench for the peripheral clock generator
`timescale 1ns/100ps
`default_nettype none
module testbench
   import pcg_pkg::*;
;
   // Source half periods in clk_sys cycles: cpu, xtal, pll, 24M, 32k, 48M
   localparam int HALF [6] = '{6, 4, 2, 5, 7, 3};
   localparam logic [11:0] RA [7] = '{12'h000, 12'h004, 12'h010, 12'h014,
                                      12'h018, 12'h01C, 12'h020};
   localparam logic [31:0] RM [7] = '{32'h0007_F7F1, 32'h000F_07F7,
                                      32'h0000_0117, 32'h0000_0003,
                                      32'h0000_11FF, 32'h0000_003F,
                                      32'h0000_0001};
   localparam logic [31:0] XRST = 32'h0004_0401;

   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  src_v   = 6'h00;
   int          hc [6]  = '{default: 0};
   pcg_srcs_t   src;
   pcg_gates_t  gates;
   pcg_clks_t   clks;
   pcg_osc_t    osc;
   logic [4:0]  clk_v;
   int          bad_count = 0;
   int          checks    = 0;

   assign src   = pcg_srcs_t'(src_v);
   assign clk_v = clks;

   pcg_clock_gen i_pcg_clock_gen (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .paddr   (paddr),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .src_i   (src),
      .gates_o (gates),
      .clks_o  (clks),
      .osc_o   (osc)
   );

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   // Sources are edge-aligned to clk_sys so measured periods are exact
   always @(posedge clk_sys) begin
      for (int i = 0; i < 6; i++) begin
         if (hc[i] == HALF[i] - 1) begin
            hc[i]    <= 0;
            src_v[i] <= ~src_v[i];
         end else begin
            hc[i] <= hc[i] + 1;
         end
      end
   end

   function automatic pcg_osc_t exp_osc(input logic [31:0] r);
      return pcg_osc_t'({r[0], r[18:17], r[16:12], r[10:9], r[8:4]});
   endfunction

   function automatic pcg_gates_t exp_gates(input logic [31:0] r);
      return pcg_gates_t'({r[19:16], r[10:4], r[2:0]});
   endfunction

   function automatic int exp_high(input int per, input int n);
      if (n == 1) begin
         return per / 2;
      end
      return (n / 2) * per;
   endfunction

   task automatic print_verdict();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         bad_count++;
         $display("Error at %0t: no pready %h %h", $time, a, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(a, 1'b1, d, rd, err);
   endtask

   task automatic wait_lvl(input int ch, input logic lvl, output int cnt);
      cnt = 0;
      while (clk_v[ch] !== lvl && cnt < 20000) begin
         @(posedge clk_sys);
         cnt++;
      end
      if (cnt >= 20000) begin
         bad_count++;
         $display("Error at %0t: clock stuck %h %h", $time, ch, lvl);
      end
   endtask

   // First rises may still belong to the old setting, so skip two
   task automatic cfg(input logic [11:0] a, input logic [31:0] d,
                      input int ch, input int per, input int n);
      int c;
      int hi;
      int lo;
      wr(a, d);
      repeat (2) begin
         wait_lvl(ch, 1'b0, c);
         wait_lvl(ch, 1'b1, c);
      end
      wait_lvl(ch, 1'b0, hi);
      wait_lvl(ch, 1'b1, lo);
      chk(32'(hi), 32'(exp_high(per, n)));
      chk(32'(hi + lo), 32'(per * n));
   endtask

   task automatic quiet(input int ch);
      int c;
      c = 0;
      repeat (40) @(posedge clk_sys);
      repeat (60) begin
         @(posedge clk_sys);
         if (clk_v[ch] !== 1'b0) c++;
      end
      chk(32'(c), 32'h0000_0000);
   endtask

   initial begin
      logic [31:0] rd;
      logic [31:0] r;
      logic [31:0] dv [2];
      logic [11:0] ua [4];
      logic        err;
      int          c;
      void'($urandom(86490));
      repeat (4) @(posedge clk_sys);
      chk(32'(gates), 32'h0000_0000);
      chk(32'(osc), 32'(exp_osc(XRST)));
      chk(32'(clks), 32'h0000_0000);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 7; i++) begin
         apb(RA[i], 1'b0, 32'h0000_0000, rd, err);
         chk(rd, (i == 0) ? XRST : 32'h0000_0000);
         chk({31'h0, err}, 32'h0000_0000);
      end
      for (int i = 0; i < 7; i++) begin
         dv[0] = 32'hFFFF_FFFF;
         dv[1] = $urandom;
         if (i == 0) r = dv[1];
         for (int k = 0; k < 2; k++) begin
            wr(RA[i], dv[k]);
            apb(RA[i], 1'b0, 32'h0000_0000, rd, err);
            chk(rd, dv[k] & RM[i]);
            if (i == 0) chk(32'(osc), 32'(exp_osc(dv[k])));
            if (i == 1) chk(32'(gates), 32'(exp_gates(dv[k])));
         end
      end
      ua = '{12'h008, 12'h00C, 12'h024, {10'($urandom_range(9, 1023)), 2'b00}};
      for (int k = 0; k < 4; k++) begin
         apb(ua[k], 1'b1, 32'hFFFF_FFFF, rd, err);
         chk({31'h0, err}, 32'h0000_0001);
         apb(ua[k], 1'b0, 32'h0000_0000, rd, err);
         chk(rd, 32'h0000_0000);
         chk({31'h0, err}, 32'h0000_0001);
      end
      chk(32'(osc), 32'(exp_osc(r & RM[0])));
      wr(12'h000, XRST);
      wr(12'h004, 32'h000F_07F7);
      // The write lands at the edge that ends the task, so look half a cycle on
      @(negedge clk_sys);
      chk(32'(gates), 32'h0000_3FFF);
      cfg(12'h010, 32'h0000_0001, 0, 8, 2);
      cfg(12'h010, 32'h0000_0017, 0, 4, 8);
      cfg(12'h010, 32'h0000_0100, 0, 8, 256);
      cfg(12'h014, 32'h0000_0000, 1, 14, 1);
      cfg(12'h014, 32'h0000_0001, 1, 8, 1);
      cfg(12'h014, 32'h0000_0002, 1, 4, 10);
      cfg(12'h014, 32'h0000_0003, 1, 10, 1);
      cfg(12'h018, 32'h0000_0000, 2, 14, 1);
      c = $urandom_range(1, 255);
      cfg(12'h018, 32'h0000_1000 | c, 2, 8, c + 1);
      cfg(12'h018, 32'h0000_1100, 2, 8, 512);
      cfg(12'h01C, 32'h0000_0000, 3, 12, 1);
      c = $urandom_range(1, 15);
      cfg(12'h01C, 32'h0000_0010 | c, 3, 8, 2 * c);
      cfg(12'h01C, 32'h0000_002F, 3, 4, 30);
      cfg(12'h01C, 32'h0000_0031, 3, 6, 2);
      cfg(12'h020, 32'h0000_0000, 4, 8, 1);
      cfg(12'h020, 32'h0000_0001, 4, 10, 1);
      wr(12'h004, 32'h000F_07E7);
      quiet(4);
      cfg(12'h014, 32'h0000_0001, 1, 8, 1);
      wr(12'h000, 32'h0000_0000);
      quiet(1);
      // Reset again in mid-run: every register returns to its reset value
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(32'(gates), 32'h0000_0000);
      chk(32'(osc), 32'(exp_osc(XRST)));
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      apb(12'h000, 1'b0, 32'h0000_0000, rd, err);
      chk(rd, XRST);
      print_verdict();
   end

   // Planned tests need roughly 20k cycles
   initial begin
      repeat (90000) @(posedge clk_sys);
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
